// *** design/usb_endpoint_mode_responder.sv ***
// token reply and endpoint mode keeper for three endpoints
// Notes on behaviour
// - each endpoint keeps a four-bit mode that selects every token reply
// - mode 0000 gives no reply at all to setup, in or out
// - mode 0001 acks setup and naks every in and out
// - after acking a setup the control endpoint mode becomes 0001
// - mode 1011 accepts setup, naks in, acks out then becomes 0001
// - mode 1001 ignores setup and in, acks out then becomes 1000
// - mode 1000 ignores setup and in, naks out
// - mode 1101 sends counted data on in; host ack moves it to 1100
// - mode 1100 ignores setup and out, naks in
// - mode 1111 accepts setup, sends data, checks out; ack moves it to 1110
// - mode 1110 accepts setup, naks in, checks status out
// - 0010 stalls in and checks out; 0110 sends empty packet, stalls out
// - 0011 stalls both, 0100 ignores both, 1010 empty in, nak out
// - stall bit on data endpoints turns 1001 out ack and 1101 in data into stall
// - status check acks only empty out with toggle one, else stall
// - data reply carries the endpoint four-bit byte count
// - reset sets every mode to 0000; it stays until firmware writes
// - control endpoint ack locks mode and count until a later read of the control endpoint
`timescale 1ns/1ps
module usb_endpoint_mode_responder
#(
   parameter int COUNT_W = 4
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tok_valid_i,
   input wire ep_mode_pkg::tok_t tok_kind_i,
   input wire logic [ep_mode_pkg::EP_W-1:0] tok_ep_i,
   input wire logic pkt_ok_i,
   input wire logic pkt_zero_len_i,
   input wire logic pkt_toggle_i,
   input wire logic host_ack_i,
   output logic resp_valid_o,
   output ep_mode_pkg::resp_t resp_kind_o,
   output logic [COUNT_W-1:0] resp_count_o,
   input wire logic fw_wr_i,
   input wire logic fw_rd_i,
   input wire logic [ep_mode_pkg::EP_W-1:0] fw_ep_i,
   input wire ep_mode_pkg::mode_t fw_mode_i,
   input wire logic fw_stall_i,
   input wire logic [COUNT_W-1:0] fw_count_i,
   output ep_mode_pkg::mode_t rd_mode_o,
   output logic rd_stall_o,
   output logic [COUNT_W-1:0] rd_count_o,
   output logic ctrl_locked_o,
   output logic in_wait_o
);
   import ep_mode_pkg::*;

   if (COUNT_W != CNT_W)
   begin : g_width_check
      $error("COUNT_W must match the four-bit byte count field");
   end

   // ==========================================
   // endpoint state
   mode_t mode [NUM_EP];
   logic stall [NUM_EP];
   logic [COUNT_W-1:0] count [NUM_EP];
   resp_t dec_resp [NUM_EP];
   mode_t dec_ack_mode [NUM_EP];
   mode_t dec_in_ack_mode [NUM_EP];

   state_t state;
   logic [EP_W-1:0] wait_ep;
   logic wait_data;
   logic locked;

   logic tok_ep_ok;
   resp_t sel_resp;
   logic dev_ack;
   logic in_sent;
   logic in_acked;
   logic ctrl_ack;

   assign tok_ep_ok = tok_valid_i && (tok_ep_i < EP_W'(NUM_EP));
   assign sel_resp = tok_ep_ok ? dec_resp[tok_ep_i] : RESP_NONE;
   assign dev_ack = sel_resp == RESP_ACK;
   assign in_sent = (sel_resp == RESP_DATA) || (sel_resp == RESP_ZLP);
   assign in_acked = (state == ST_IN_WAIT) && host_ack_i && !tok_valid_i;
   assign ctrl_ack = (dev_ack && tok_ep_i == CTRL_EP) || (in_acked && wait_ep == CTRL_EP);

   // ==========================================
   // per endpoint decode and mode keeping
   for (genvar e = 0; e < NUM_EP; e++)
   begin : g_ep
      logic hit;
      logic wr_ok;

      assign hit = tok_ep_ok && tok_ep_i == EP_W'(e);
      assign wr_ok = fw_wr_i && fw_ep_i == EP_W'(e) && !(e == 0 && locked);

      ep_mode_decode u_dec
      (
         .mode_i(mode[e]),
         .stall_i(stall[e]),
         .is_ctrl_i(e == 0),
         .kind_i(tok_kind_i),
         .pkt_ok_i(pkt_ok_i),
         .zero_len_i(pkt_zero_len_i),
         .toggle_i(pkt_toggle_i),
         .resp_o(dec_resp[e]),
         .ack_mode_o(dec_ack_mode[e]),
         .in_ack_mode_o(dec_in_ack_mode[e])
      );

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            mode[e] <= MODE_RESET;
         end
         else if (hit && dev_ack)
         begin
            mode[e] <= dec_ack_mode[e];
         end
         else if (in_acked && wait_data && wait_ep == EP_W'(e))
         begin
            mode[e] <= dec_in_ack_mode[e];
         end
         else if (wr_ok)
         begin
            mode[e] <= fw_mode_i;
         end
      end

      always_ff @(posedge clk_i)
      begin
         if (rst_i)
         begin
            stall[e] <= 1'b0;
            count[e] <= '0;
         end
         else if (wr_ok)
         begin
            stall[e] <= fw_stall_i;
            count[e] <= fw_count_i;
         end
      end
   end

   // ==========================================
   // reply output
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         resp_valid_o <= 1'b0;
         resp_kind_o <= RESP_NONE;
         resp_count_o <= '0;
      end
      else
      begin
         resp_valid_o <= sel_resp != RESP_NONE;
         resp_kind_o <= sel_resp;
         resp_count_o <= (sel_resp == RESP_DATA) ? count[tok_ep_i] : '0;
      end
   end

   // ==========================================
   // wait for host handshake after in data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= ST_IDLE;
         wait_ep <= '0;
         wait_data <= 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (in_sent)
               begin
                  state <= ST_IN_WAIT;
                  wait_ep <= tok_ep_i;
                  wait_data <= sel_resp == RESP_DATA;
               end
            end
            ST_IN_WAIT:
            begin
               if (in_sent)
               begin
                  wait_ep <= tok_ep_i;
                  wait_data <= sel_resp == RESP_DATA;
               end
               else if (tok_valid_i || host_ack_i)
               begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================
   // control endpoint write lock
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         locked <= 1'b0;
      end
      else if (ctrl_ack)
      begin
         locked <= 1'b1;
      end
      else if (fw_rd_i && fw_ep_i == CTRL_EP)
      begin
         locked <= 1'b0;
      end
   end

   // ==========================================
   // firmware read port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_mode_o <= MODE_RESET;
         rd_stall_o <= 1'b0;
         rd_count_o <= '0;
      end
      else if (fw_rd_i)
      begin
         rd_mode_o <= (fw_ep_i < EP_W'(NUM_EP)) ? mode[fw_ep_i] : MODE_RESET;
         rd_stall_o <= (fw_ep_i < EP_W'(NUM_EP)) ? stall[fw_ep_i] : 1'b0;
         rd_count_o <= (fw_ep_i < EP_W'(NUM_EP)) ? count[fw_ep_i] : '0;
      end
   end

   assign ctrl_locked_o = locked;
   assign in_wait_o = state == ST_IN_WAIT;

   // ==========================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence ep0_setup_ack;
      tok_ep_ok && tok_ep_i == CTRL_EP && tok_kind_i == TOK_SETUP && dev_ack;
   endsequence

   sequence data_sent_ep1;
      tok_ep_ok && tok_ep_i == 2'h1 && mode[1] == MODE_ACK_IN && !stall[1]
         && tok_kind_i == TOK_IN;
   endsequence

   sequence host_acks;
      host_ack_i && !tok_valid_i;
   endsequence

   sequence bus_idle;
      !tok_valid_i && !host_ack_i;
   endsequence

   disabled_quiet_a: assert property (tok_ep_ok && mode[tok_ep_i] == MODE_DISABLE
      |=> !resp_valid_o) else $error("disabled endpoint replied");

   nak_mode_a: assert property (tok_ep_ok && mode[tok_ep_i] == MODE_NAK_IO
      && (tok_kind_i == TOK_IN || (tok_kind_i == TOK_OUT && pkt_ok_i))
      |=> resp_valid_o && resp_kind_o == RESP_NAK) else $error("no nak in 0001");

   setup_to_nak_a: assert property (ep0_setup_ack |=> mode[0] == MODE_NAK_IO
      && resp_kind_o == RESP_ACK) else $error("setup ack kept mode");

   out_ack_back_a: assert property (tok_ep_ok && tok_ep_i == 2'h2 && tok_kind_i == TOK_OUT
      && pkt_ok_i && mode[2] == MODE_ACK_OUT_NAK_IN
      |=> resp_kind_o == RESP_ACK && mode[2] == MODE_NAK_IO) else $error("1011 out");

   out_ack_step_a: assert property (tok_ep_ok && tok_ep_i == 2'h1 && tok_kind_i == TOK_OUT
      && pkt_ok_i && mode[1] == MODE_ACK_OUT && !stall[1]
      |=> resp_kind_o == RESP_ACK && mode[1] == MODE_NAK_OUT) else $error("1001 out");

   stall_bit_a: assert property (tok_ep_ok && tok_ep_i == 2'h1 && tok_kind_i == TOK_OUT
      && pkt_ok_i && mode[1] == MODE_ACK_OUT && stall[1]
      |=> resp_kind_o == RESP_STALL && $stable(mode[1])) else $error("stall ignored");

   in_ack_step_a: assert property (data_sent_ep1 ##1 bus_idle ##1 host_acks
      |=> mode[1] == MODE_NAK_IN) else $error("1101 not advanced");

   count_reply_a: assert property (tok_ep_ok && sel_resp == RESP_DATA
      |=> resp_kind_o == RESP_DATA && resp_count_o == $past(count[tok_ep_i]))
      else $error("wrong byte count");

   status_check_a: assert property (tok_ep_ok && tok_kind_i == TOK_OUT && pkt_ok_i
      && mode[tok_ep_i] == MODE_NAK_IN_CHK && !(pkt_zero_len_i && pkt_toggle_i)
      |=> resp_kind_o == RESP_STALL) else $error("bad status acked");

   lock_hold_a: assert property (locked && fw_wr_i && fw_ep_i == CTRL_EP && !fw_rd_i
      && !tok_valid_i && !host_ack_i |=> $stable(mode[0]) && $stable(count[0]))
      else $error("locked write landed");

   reset_disable_a: assert property (disable iff (1'b0) rst_i |=> mode[0] == MODE_DISABLE
      && mode[1] == MODE_DISABLE && mode[2] == MODE_DISABLE) else $error("reset mode");
endmodule : usb_endpoint_mode_responder

// *** common/ep_mode_pkg.sv ***
// shared codes and sizes for the endpoint mode responder
package ep_mode_pkg;
   // ==========================================
   // sizes
   localparam int NUM_EP = 3;
   localparam int EP_W = 2;
   localparam int MODE_W = 4;
   localparam int CNT_W = 4;
   localparam logic [EP_W-1:0] CTRL_EP = 2'h0;

   // ==========================================
   // endpoint mode codes
   typedef enum logic [MODE_W-1:0] {
      MODE_DISABLE = 4'b0000,
      MODE_NAK_IO = 4'b0001,
      MODE_STATUS_OUT = 4'b0010,
      MODE_STALL_IO = 4'b0011,
      MODE_IGNORE_IO = 4'b0100,
      MODE_RSVD_5 = 4'b0101,
      MODE_STATUS_IN = 4'b0110,
      MODE_RSVD_7 = 4'b0111,
      MODE_NAK_OUT = 4'b1000,
      MODE_ACK_OUT = 4'b1001,
      MODE_NAK_OUT_ZLP = 4'b1010,
      MODE_ACK_OUT_NAK_IN = 4'b1011,
      MODE_NAK_IN = 4'b1100,
      MODE_ACK_IN = 4'b1101,
      MODE_NAK_IN_CHK = 4'b1110,
      MODE_ACK_IN_CHK = 4'b1111
   } mode_t;

   localparam mode_t MODE_RESET = MODE_DISABLE;

   // ==========================================
   // token kinds and replies
   typedef enum logic [1:0] {
      TOK_SETUP = 2'b00,
      TOK_IN = 2'b01,
      TOK_OUT = 2'b10
   } tok_t;

   typedef enum logic [2:0] {
      RESP_NONE = 3'b000,
      RESP_ACK = 3'b001,
      RESP_NAK = 3'b010,
      RESP_STALL = 3'b011,
      RESP_DATA = 3'b100,
      RESP_ZLP = 3'b101
   } resp_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_IN_WAIT = 1'b1
   } state_t;
endpackage : ep_mode_pkg

// *** design/ep_mode_decode.sv ***
// reply decoder for one endpoint
`timescale 1ns/1ps
module ep_mode_decode
(
   input wire ep_mode_pkg::mode_t mode_i,
   input wire logic stall_i,
   input wire logic is_ctrl_i,
   input wire ep_mode_pkg::tok_t kind_i,
   input wire logic pkt_ok_i,
   input wire logic zero_len_i,
   input wire logic toggle_i,
   output ep_mode_pkg::resp_t resp_o,
   output ep_mode_pkg::mode_t ack_mode_o,
   output ep_mode_pkg::mode_t in_ack_mode_o
);
   import ep_mode_pkg::*;

   logic accept_setup;
   logic stall_on;
   logic status_ok;

   assign stall_on = stall_i && !is_ctrl_i;
   assign status_ok = zero_len_i && toggle_i;

   // ==========================================
   // setup acceptance
   always_comb
   begin
      unique case (mode_i)
         MODE_NAK_IO, MODE_STATUS_OUT, MODE_STALL_IO, MODE_IGNORE_IO, MODE_STATUS_IN,
         MODE_NAK_OUT_ZLP, MODE_ACK_OUT_NAK_IN, MODE_NAK_IN_CHK, MODE_ACK_IN_CHK:
            accept_setup = 1'b1;
         default:
            accept_setup = 1'b0;
      endcase
   end

   // ==========================================
   // mode after host acks data
   always_comb
   begin
      unique case (mode_i)
         MODE_ACK_IN: in_ack_mode_o = MODE_NAK_IN;
         MODE_ACK_IN_CHK: in_ack_mode_o = MODE_NAK_IN_CHK;
         default: in_ack_mode_o = mode_i;
      endcase
   end

   // ==========================================
   // reply per token
   always_comb
   begin
      resp_o = RESP_NONE;
      ack_mode_o = mode_i;
      unique case (kind_i)
         TOK_SETUP:
         begin
            if (accept_setup && pkt_ok_i)
            begin
               resp_o = RESP_ACK;
               ack_mode_o = MODE_NAK_IO;
            end
         end
         TOK_IN:
         begin
            unique case (mode_i)
               MODE_NAK_IO, MODE_ACK_OUT_NAK_IN, MODE_NAK_IN, MODE_NAK_IN_CHK:
                  resp_o = RESP_NAK;
               MODE_STATUS_OUT, MODE_STALL_IO:
                  resp_o = RESP_STALL;
               MODE_STATUS_IN, MODE_NAK_OUT_ZLP:
                  resp_o = RESP_ZLP;
               MODE_ACK_IN:
                  resp_o = stall_on ? RESP_STALL : RESP_DATA;
               MODE_ACK_IN_CHK:
                  resp_o = RESP_DATA;
               default:
                  resp_o = RESP_NONE;
            endcase
         end
         default:
         begin
            if (pkt_ok_i)
            begin
               unique case (mode_i)
                  MODE_NAK_IO, MODE_NAK_OUT, MODE_NAK_OUT_ZLP:
                     resp_o = RESP_NAK;
                  MODE_STALL_IO, MODE_STATUS_IN:
                     resp_o = RESP_STALL;
                  MODE_ACK_OUT:
                  begin
                     resp_o = stall_on ? RESP_STALL : RESP_ACK;
                     ack_mode_o = MODE_NAK_OUT;
                  end
                  MODE_ACK_OUT_NAK_IN:
                  begin
                     resp_o = RESP_ACK;
                     ack_mode_o = MODE_NAK_IO;
                  end
                  MODE_STATUS_OUT, MODE_NAK_IN_CHK, MODE_ACK_IN_CHK:
                  begin
                     resp_o = status_ok ? RESP_ACK : RESP_STALL;
                     ack_mode_o = (mode_i == MODE_ACK_IN_CHK) ? MODE_NAK_IN_CHK : mode_i;
                  end
                  default:
                     resp_o = RESP_NONE;
               endcase
            end
         end
      endcase
   end
endmodule : ep_mode_decode

// *** tb/usb_host_model.sv ***
// host token source facing the endpoint mode responder
`timescale 1ns/1ps
module usb_host_model
(
   input wire logic clk_i,
   output logic tok_valid_o,
   output ep_mode_pkg::tok_t tok_kind_o,
   output logic [ep_mode_pkg::EP_W-1:0] tok_ep_o,
   output logic pkt_ok_o,
   output logic pkt_zero_len_o,
   output logic pkt_toggle_o,
   output logic host_ack_o
);
   import ep_mode_pkg::*;

   initial
   begin
      tok_valid_o = 1'b0;
      tok_kind_o = TOK_SETUP;
      tok_ep_o = 2'h0;
      pkt_ok_o = 1'b0;
      pkt_zero_len_o = 1'b0;
      pkt_toggle_o = 1'b0;
      host_ack_o = 1'b0;
   end

   // ==========================================
   // one token, then a changed idle pattern
   task send(input tok_t kind, input logic [1:0] ep, input logic ok, zl, tog);
      @(negedge clk_i);
      tok_valid_o = 1'b1;
      tok_kind_o = kind;
      tok_ep_o = ep;
      pkt_ok_o = ok;
      pkt_zero_len_o = zl;
      pkt_toggle_o = tog;
      @(negedge clk_i);
      tok_valid_o = 1'b0;
      tok_kind_o = tok_t'(~kind);
      tok_ep_o = ~ep;
      pkt_ok_o = ~ok;
      pkt_zero_len_o = ~zl;
      pkt_toggle_o = ~tog;
   endtask : send

   // ==========================================
   // host handshake after an in reply; caller stands on a falling edge
   task ack();
      host_ack_o = 1'b1;
      @(negedge clk_i);
      host_ack_o = 1'b0;
   endtask : ack
endmodule : usb_host_model

// *** tb/usb_endpoint_mode_responder_tb_top.sv ***
// self-checking bench for the endpoint mode responder
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module usb_endpoint_mode_responder_tb_top;
   import ep_mode_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic tok_valid_i, pkt_ok_i, pkt_zero_len_i, pkt_toggle_i, host_ack_i;
   tok_t tok_kind_i;
   logic [1:0] tok_ep_i;
   logic fw_wr_i = 1'b0;
   logic fw_rd_i = 1'b0;
   logic [1:0] fw_ep_i = 2'h0;
   mode_t fw_mode_i = MODE_DISABLE;
   logic fw_stall_i = 1'b0;
   logic [3:0] fw_count_i = 4'h0;
   logic resp_valid_o, rd_stall_o, ctrl_locked_o, in_wait_o;
   resp_t resp_kind_o;
   mode_t rd_mode_o;
   logic [3:0] resp_count_o, rd_count_o;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;

   usb_endpoint_mode_responder usb_endpoint_mode_responder_inst (.clk_i(clk_i), .rst_i(rst_i),
      .tok_valid_i(tok_valid_i), .tok_kind_i(tok_kind_i), .tok_ep_i(tok_ep_i),
      .pkt_ok_i(pkt_ok_i), .pkt_zero_len_i(pkt_zero_len_i), .pkt_toggle_i(pkt_toggle_i),
      .host_ack_i(host_ack_i), .resp_valid_o(resp_valid_o), .resp_kind_o(resp_kind_o),
      .resp_count_o(resp_count_o), .fw_wr_i(fw_wr_i), .fw_rd_i(fw_rd_i), .fw_ep_i(fw_ep_i),
      .fw_mode_i(fw_mode_i), .fw_stall_i(fw_stall_i), .fw_count_i(fw_count_i),
      .rd_mode_o(rd_mode_o), .rd_stall_o(rd_stall_o), .rd_count_o(rd_count_o),
      .ctrl_locked_o(ctrl_locked_o), .in_wait_o(in_wait_o));

   usb_host_model usb_host_model_inst (.clk_i(clk_i), .tok_valid_o(tok_valid_i),
      .tok_kind_o(tok_kind_i), .tok_ep_o(tok_ep_i), .pkt_ok_o(pkt_ok_i),
      .pkt_zero_len_o(pkt_zero_len_i), .pkt_toggle_o(pkt_toggle_i), .host_ack_o(host_ack_i));

   // ==========================================
   // clock, timeout and verdict
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         test_done();
      end
   end

   task test_done();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done

   // ==========================================
   // expected replies and mode updates
   function automatic resp_t exp_resp(input mode_t m, input logic st, ctl, input tok_t k,
                                      input logic ok, zl, tog);
      resp_t chk;
      chk = (zl && tog) ? RESP_ACK : RESP_STALL;
      if (k != TOK_IN && !ok)
         return RESP_NONE;
      if (k == TOK_SETUP)
         return (m inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'ha, 4'hb, 4'he, 4'hf}) ?
                RESP_ACK : RESP_NONE;
      if (k == TOK_IN)
         case (m)
            4'h1, 4'hb, 4'hc, 4'he: return RESP_NAK;
            4'h2, 4'h3: return RESP_STALL;
            4'h6, 4'ha: return RESP_ZLP;
            4'hd: return (st && !ctl) ? RESP_STALL : RESP_DATA;
            4'hf: return RESP_DATA;
            default: return RESP_NONE;
         endcase
      case (m)
         4'h1, 4'h8, 4'ha: return RESP_NAK;
         4'h3, 4'h6: return RESP_STALL;
         4'hb: return RESP_ACK;
         4'h9: return (st && !ctl) ? RESP_STALL : RESP_ACK;
         4'h2, 4'he, 4'hf: return chk;
         default: return RESP_NONE;
      endcase
   endfunction : exp_resp

   function automatic mode_t exp_next(input mode_t m, input tok_t k, input resp_t r);
      if (r != RESP_ACK)
         return m;
      if (k == TOK_SETUP)
         return MODE_NAK_IO;
      case (m)
         MODE_ACK_OUT_NAK_IN: return MODE_NAK_IO;
         MODE_ACK_OUT: return MODE_NAK_OUT;
         MODE_ACK_IN_CHK: return MODE_NAK_IN_CHK;
         default: return m;
      endcase
   endfunction : exp_next

   // ==========================================
   // firmware and token helpers
   task do_reset();
      @(negedge clk_i);
      rst_i = 1'b1;
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
   endtask : do_reset

   task fw_write(input logic [1:0] ep, input mode_t m, input logic st, input logic [3:0] c,
                 input logic rd_first);
      if (rd_first)
      begin
         @(negedge clk_i);
         fw_rd_i = 1'b1;
         fw_ep_i = ep;
      end
      @(negedge clk_i);
      fw_rd_i = 1'b0;
      fw_wr_i = 1'b1;
      fw_ep_i = ep;
      fw_mode_i = m;
      fw_stall_i = st;
      fw_count_i = c;
      @(negedge clk_i);
      fw_wr_i = 1'b0;
   endtask : fw_write

   task fw_check(input logic [1:0] ep, input mode_t m, input logic st, input logic [3:0] c);
      @(negedge clk_i);
      fw_rd_i = 1'b1;
      fw_ep_i = ep;
      @(negedge clk_i);
      fw_rd_i = 1'b0;
      `CHK(rd_mode_o, m);
      `CHK(rd_stall_o, st);
      `CHK(rd_count_o, c);
   endtask : fw_check

   task tok_chk(input tok_t k, input logic [1:0] ep, input logic ok, zl, tog, input resp_t r,
                input logic [3:0] c);
      usb_host_model_inst.send(k, ep, ok, zl, tog);
      `CHK(resp_valid_o, r != RESP_NONE);
      `CHK(resp_kind_o, r);
      `CHK(resp_count_o, c);
      `CHK(in_wait_o, r == RESP_DATA || r == RESP_ZLP);
      @(negedge clk_i);
      `CHK(resp_valid_o, 1'b0);
   endtask : tok_chk

   // ==========================================
   // scenarios
   task t_reset_values();
      `CHK(resp_valid_o, 1'b0);
      `CHK(ctrl_locked_o, 1'b0);
      `CHK(in_wait_o, 1'b0);
      for (int e = 0; e < 4; e++)
         fw_check(2'(e), MODE_RESET, 1'b0, 4'h0);
      tok_chk(TOK_IN, 2'h1, 1'b1, 1'b0, 1'b0, RESP_NONE, 4'h0);
   endtask : t_reset_values

   task t_mode_table(input logic [1:0] ep, input logic st, zl, tog, ok);
      mode_t m;
      resp_t r;
      tok_t k;
      logic [3:0] c;
      for (int i = 0; i < 16; i++)
         for (int j = 0; j < 3; j++)
         begin
            m = mode_t'(i);
            k = tok_t'(j);
            c = 4'hf - 4'(i);
            r = exp_resp(m, st, ep == CTRL_EP, k, ok, zl, tog);
            fw_write(ep, m, st, c, 1'b1);
            tok_chk(k, ep, ok, zl, tog, r, (r == RESP_DATA) ? c : 4'h0);
            fw_check(ep, exp_next(m, k, r), st, c);
         end
   endtask : t_mode_table

   task t_host_ack(input logic [1:0] ep, input mode_t m, input logic [3:0] c, input resp_t r,
                   input mode_t nm);
      fw_write(ep, m, 1'b0, c, 1'b1);
      tok_chk(TOK_IN, ep, 1'b1, 1'b0, 1'b0, r, (r == RESP_DATA) ? c : 4'h0);
      usb_host_model_inst.ack();
      `CHK(in_wait_o, 1'b0);
      if (ep == CTRL_EP)
         `CHK(ctrl_locked_o, 1'b1);
      fw_check(ep, nm, 1'b0, c);
   endtask : t_host_ack

   task t_lock();
      fw_write(CTRL_EP, MODE_STALL_IO, 1'b0, 4'h3, 1'b1);
      tok_chk(TOK_SETUP, CTRL_EP, 1'b1, 1'b0, 1'b0, RESP_ACK, 4'h0);
      `CHK(ctrl_locked_o, 1'b1);
      fw_write(CTRL_EP, MODE_IGNORE_IO, 1'b0, 4'h9, 1'b0);
      fw_check(CTRL_EP, MODE_NAK_IO, 1'b0, 4'h3);
      `CHK(ctrl_locked_o, 1'b0);
      fw_write(CTRL_EP, MODE_IGNORE_IO, 1'b0, 4'h9, 1'b0);
      fw_check(CTRL_EP, MODE_IGNORE_IO, 1'b0, 4'h9);
   endtask : t_lock

   task t_mid_reset();
      fw_write(2'h3, MODE_NAK_IO, 1'b0, 4'h4, 1'b1);
      tok_chk(TOK_SETUP, 2'h3, 1'b1, 1'b0, 1'b0, RESP_NONE, 4'h0);
      fw_write(2'h1, MODE_ACK_IN, 1'b1, 4'h7, 1'b1);
      do_reset();
      t_reset_values();
   endtask : t_mid_reset

   initial
   begin
      do_reset();
      t_reset_values();
      t_mode_table(CTRL_EP, 1'b0, 1'b1, 1'b1, 1'b1);
      t_mode_table(2'h1, 1'b0, 1'b1, 1'b1, 1'b1);
      t_mode_table(2'h1, 1'b1, 1'b1, 1'b1, 1'b1);
      t_mode_table(2'h2, 1'b1, 1'b0, 1'b1, 1'b1);
      t_mode_table(2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
      t_host_ack(2'h1, MODE_ACK_IN, 4'h5, RESP_DATA, MODE_NAK_IN);
      t_host_ack(2'h2, MODE_ACK_IN_CHK, 4'hf, RESP_DATA, MODE_NAK_IN_CHK);
      t_host_ack(CTRL_EP, MODE_STATUS_IN, 4'h2, RESP_ZLP, MODE_STATUS_IN);
      t_lock();
      t_mid_reset();
      test_done();
   end
endmodule : usb_endpoint_mode_responder_tb_top
